// ==== core/pdcb_pkg.sv ====
`default_nettype none

package pdcb_pkg;

    // ------------------------------------------------------------
    // bank geometry and register indices
    // ------------------------------------------------------------
    localparam int             REG_COUNT        = 42;
    localparam int             IDX_W            = 6;
    localparam logic [5:0]     IDX_LIMIT        = 6'h2A;
    localparam int             IDX_SUPPLY_CTRL  = 0;
    localparam int             IDX_SUPPLY_WIN   = 1;
    localparam int             IDX_GENERAL_ONE  = 2;
    localparam int             IDX_GENERAL_THR  = 3;
    localparam int             IDX_PIN_BASE     = 4;
    localparam int             IDX_STARTUP_PIN  = 15;
    localparam int             IDX_LEVELS_LOW   = 16;
    localparam int             IDX_LEVELS_HIGH  = 17;
    localparam int             IDX_GROUP_BASE   = 18;
    localparam int             IDX_ACTION_ONE   = 21;
    localparam int             IDX_ACTION_TWO   = 22;
    localparam int             IDX_TRIG_BASE    = 23;
    localparam int             IDX_IRQ_BASE     = 26;
    localparam int             IRQ_REGS         = 16;
    localparam int             IDX_SUPPLY_IRQ   = 31;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int             MON_EN_BIT       = 0;
    localparam int             MON_FSEL_LSB     = 1;
    localparam logic [1:0]     MON_FSEL_20US    = 2'h1;
    localparam int             FAST_OVP_BIT     = 0;
    localparam int             LP_DISABLES_BIT  = 0;
    localparam int             PIN_OD_BIT       = 0;
    localparam int             PIN_DIR_BIT      = 1;
    localparam int             PIN_SEL_LSB      = 2;
    localparam logic [2:0]     PIN_SEL_PLAIN    = 3'h0;
    localparam int             PIN_FILT_BIT     = 7;
    localparam int             START_SEL_LSB    = 0;
    localparam logic [1:0]     START_SEL_BUTTON = 2'h1;
    localparam int             START_FILT_BIT   = 4;
    localparam int             START_POL_BIT    = 5;
    localparam int             SUPPLY_OV_MASK   = 0;
    localparam int             SUPPLY_UV_MASK   = 1;
    localparam logic [1:0]     GROUP_SAFETY     = 2'h1;
    localparam logic [1:0]     GROUP_MAIN       = 2'h2;

    typedef enum logic [1:0] {
        PDCB_IMMEDIATE_OFF = 2'h0,
        PDCB_ORDERLY_OFF   = 2'h1,
        PDCB_SAFETY_ERROR  = 2'h2,
        PDCB_MAIN_ERROR    = 2'h3
    } pdcb_action_t;

    // ------------------------------------------------------------
    // power-up defaults, index 41 first
    // ------------------------------------------------------------
    localparam logic [41:0][7:0] BANK_DEFAULTS = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h04, 8'h05, 8'h3C,
        8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h15, 8'h55, 8'h55, 8'h01, 8'h1E, 8'h06, 8'hA5, 8'h6A,
        8'h00, 8'h00, 8'h58, 8'h0B, 8'h40, 8'hC0, 8'hCC, 8'hC4,
        8'h02, 8'h02, 8'h02, 8'h02, 8'h08, 8'h04, 8'h01, 8'h02,
        8'h3F, 8'h03
    };

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int             CLK_PERIOD_NS    = 4;
    localparam int             CNT_W            = 24;
    localparam int             PIN_FILTER_NS    = 8000;
    localparam int             SLOW_OV_NS       = 4000;
    localparam int             SUPPLY_FILTER_NS = 20000;
    localparam int             BUTTON_FILTER_MS = 50;
    localparam int             PIN_FILTER_CYC   =
        (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int             SLOW_OV_CYC      =
        (SLOW_OV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int             SUPPLY_FILTER_CYC =
        (SUPPLY_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int             BUTTON_FILTER_CYC =
        (BUTTON_FILTER_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pdcb_pkg

`default_nettype wire

// ==== core/pdcb_config_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

module pdcb_config_bank
    import pdcb_pkg::*;
#(
    parameter int unsigned SUPPLY_CYCLES = SUPPLY_FILTER_CYC,
    parameter int unsigned BUTTON_CYCLES = BUTTON_FILTER_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 nvm_load,
    input  wire logic                 boot_self_test_done,
    input  wire logic                 low_power_mode_enable,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    input  wire logic [IDX_W-1:0]     reg_index,
    input  wire logic [7:0]           reg_wdata,
    output var  logic [7:0]           reg_rdata,
    output var  logic                 reg_rvalid,
    input  wire logic [10:0]          pin_input,
    output var  logic [10:0]          pin_out,
    output var  logic [10:0]          pin_oe,
    output var  logic [10:0]          pin_trigger,
    input  wire logic                 power_button_input,
    output var  logic                 startup_request,
    input  wire logic                 supply_ov_raw,
    input  wire logic                 supply_uv_raw,
    output var  logic                 monitor_active,
    output var  logic                 supply_ov_flag,
    output var  logic                 supply_uv_flag,
    input  wire logic [127:0]         irq_sources,
    output var  logic                 interrupt_pin_oe,
    output var  logic [9:0]           safety_group_members,
    output var  logic [9:0]           main_group_members,
    output var  pdcb_action_t         safety_group_action,
    output var  pdcb_action_t         main_group_action,
    output var  pdcb_action_t         other_group_action,
    output var  pdcb_action_t         severe_fault_action,
    output var  pdcb_action_t         moderate_fault_action
);

    localparam int CH      = 14;
    localparam int CH_STRT = 11;
    localparam int CH_OV   = 12;
    localparam int CH_UV   = 13;

    logic [7:0]       bank [REG_COUNT];
    logic [CH-1:0]    sync1;
    logic [CH-1:0]    sync2;
    logic [CH-1:0]    filt;
    logic [CNT_W-1:0] fcnt  [CH];
    logic [CNT_W-1:0] limit [CH];
    logic [10:0]      levels;
    logic [19:0]      groups;
    logic [127:0]     irq_masks;
    logic             next_monitor_active;

    function automatic logic filter_settled(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] lim
    );
        return (lim == '0) || (cnt >= lim - CNT_W'(1));
    endfunction : filter_settled

    function automatic logic [1:0] field2(
        input logic [7:0] value,
        input int         lsb
    );
        return value[lsb +: 2];
    endfunction : field2

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    // hardware clear of the supply masks wins over a host write
    always_ff @(posedge clk) begin
        if (srst || nvm_load) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                bank[i] <= BANK_DEFAULTS[i];
            end
        end else begin
            if (reg_write && reg_index < IDX_LIMIT) begin
                bank[reg_index] <= reg_wdata;
            end
            if (boot_self_test_done) begin
                bank[IDX_SUPPLY_IRQ][SUPPLY_OV_MASK] <= 1'b0;
                bank[IDX_SUPPLY_IRQ][SUPPLY_UV_MASK] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            reg_rdata  <= (reg_index < IDX_LIMIT) ? bank[reg_index]
                                                  : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // input synchronisers and deglitch filters
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {supply_uv_raw, supply_ov_raw,
                      power_button_input, pin_input};
            sync2 <= sync1;
        end
    end

    always_comb begin
        for (int i = 0; i < 11; i++) begin
            limit[i] = bank[IDX_PIN_BASE + i][PIN_FILT_BIT]
                     ? CNT_W'(PIN_FILTER_CYC) : '0;
        end
        if (!bank[IDX_STARTUP_PIN][START_FILT_BIT]) begin
            limit[CH_STRT] = '0;
        end else if (field2(bank[IDX_STARTUP_PIN], START_SEL_LSB)
                     == START_SEL_BUTTON) begin
            limit[CH_STRT] = CNT_W'(BUTTON_CYCLES);
        end else begin
            limit[CH_STRT] = CNT_W'(PIN_FILTER_CYC);
        end
        limit[CH_UV] = (field2(bank[IDX_SUPPLY_CTRL], MON_FSEL_LSB)
                        == MON_FSEL_20US) ? CNT_W'(SUPPLY_CYCLES) : '0;
        // slow path unless the fast option is set
        limit[CH_OV] = bank[IDX_GENERAL_ONE][FAST_OVP_BIT]
                     ? limit[CH_UV] : CNT_W'(SLOW_OV_CYC);
    end

    // a changed level must hold for the whole window to pass
    always_ff @(posedge clk) begin
        if (srst) begin
            filt <= '0;
            for (int c = 0; c < CH; c++) begin
                fcnt[c] <= '0;
            end
        end else begin
            for (int c = 0; c < CH; c++) begin
                if (sync2[c] == filt[c]) begin
                    fcnt[c] <= '0;
                end else if (filter_settled(fcnt[c], limit[c])) begin
                    filt[c] <= sync2[c];
                    fcnt[c] <= '0;
                end else begin
                    fcnt[c] <= fcnt[c] + CNT_W'(1);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign levels = {bank[IDX_LEVELS_HIGH][2:0], bank[IDX_LEVELS_LOW]};

    // alternate functions own the pad, so only plain pins drive here
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_out     <= '0;
            pin_oe      <= '0;
            pin_trigger <= '0;
        end else begin
            for (int i = 0; i < 11; i++) begin
                if (bank[IDX_PIN_BASE + i][PIN_SEL_LSB +: 3]
                    == PIN_SEL_PLAIN
                    && bank[IDX_PIN_BASE + i][PIN_DIR_BIT]) begin
                    pin_out[i] <= levels[i];
                    pin_oe[i]  <= !bank[IDX_PIN_BASE + i][PIN_OD_BIT]
                                  || !levels[i];
                end else begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i]  <= 1'b0;
                end
                pin_trigger[i] <= bank[IDX_TRIG_BASE + i / 4][2 * (i % 4)]
                                ? bank[IDX_TRIG_BASE + i / 4][2 * (i % 4) + 1]
                                : filt[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            startup_request <= 1'b0;
        end else if (field2(bank[IDX_STARTUP_PIN], START_SEL_LSB)
                     == START_SEL_BUTTON) begin
            startup_request <= !filt[CH_STRT];
        end else begin
            startup_request <= filt[CH_STRT]
                             ^ bank[IDX_STARTUP_PIN][START_POL_BIT];
        end
    end

    // ------------------------------------------------------------
    // supply monitor
    // ------------------------------------------------------------
    assign next_monitor_active = bank[IDX_SUPPLY_CTRL][MON_EN_BIT]
        && !(low_power_mode_enable
             && bank[IDX_GENERAL_THR][LP_DISABLES_BIT]);

    always_ff @(posedge clk) begin
        if (srst) begin
            monitor_active <= 1'b0;
            supply_ov_flag <= 1'b0;
            supply_uv_flag <= 1'b0;
        end else begin
            monitor_active <= next_monitor_active;
            supply_ov_flag <= next_monitor_active && filt[CH_OV];
            supply_uv_flag <= next_monitor_active && filt[CH_UV];
        end
    end

    // ------------------------------------------------------------
    // interrupt pin and group / action decode
    // ------------------------------------------------------------
    always_comb begin
        for (int r = 0; r < IRQ_REGS; r++) begin
            irq_masks[8 * r +: 8] = bank[IDX_IRQ_BASE + r];
        end
    end

    // open drain: enable high pulls the line low
    always_ff @(posedge clk) begin
        if (srst) begin
            interrupt_pin_oe <= 1'b0;
        end else begin
            interrupt_pin_oe <= |(irq_sources & ~irq_masks);
        end
    end

    assign groups = {bank[IDX_GROUP_BASE + 2][3:0],
                     bank[IDX_GROUP_BASE + 1], bank[IDX_GROUP_BASE]};

    always_ff @(posedge clk) begin
        if (srst) begin
            safety_group_members <= '0;
            main_group_members   <= '0;
        end else begin
            for (int k = 0; k < 10; k++) begin
                safety_group_members[k] <= groups[2 * k +: 2]
                                           == GROUP_SAFETY;
                main_group_members[k]   <= groups[2 * k +: 2]
                                           == GROUP_MAIN;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            safety_group_action   <= PDCB_IMMEDIATE_OFF;
            main_group_action     <= PDCB_IMMEDIATE_OFF;
            other_group_action    <= PDCB_IMMEDIATE_OFF;
            severe_fault_action   <= PDCB_IMMEDIATE_OFF;
            moderate_fault_action <= PDCB_IMMEDIATE_OFF;
        end else begin
            safety_group_action   <= pdcb_action_t'(
                field2(bank[IDX_ACTION_ONE], 0));
            main_group_action     <= pdcb_action_t'(
                field2(bank[IDX_ACTION_ONE], 2));
            other_group_action    <= pdcb_action_t'(
                field2(bank[IDX_ACTION_ONE], 4));
            severe_fault_action   <= pdcb_action_t'(
                field2(bank[IDX_ACTION_ONE], 6));
            moderate_fault_action <= pdcb_action_t'(
                field2(bank[IDX_ACTION_TWO], 0));
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_NVM_LOAD: assert property (
        nvm_load |=> bank[IDX_SUPPLY_IRQ] == BANK_DEFAULTS[IDX_SUPPLY_IRQ]
                     && bank[IDX_ACTION_ONE] == BANK_DEFAULTS[IDX_ACTION_ONE])
        else $error("defaults not copied on load");

    AST_SELF_TEST_CLEAR: assert property (
        boot_self_test_done && !nvm_load
        |=> bank[IDX_SUPPLY_IRQ][1:0] == 2'h0)
        else $error("supply irq masks not cleared");

    AST_HOST_WRITE: assert property (
        reg_write && !nvm_load && !boot_self_test_done
        && reg_index < IDX_LIMIT
        |=> bank[$past(reg_index)] == $past(reg_wdata))
        else $error("host write not stored");

    AST_LOW_POWER_OFF: assert property (
        low_power_mode_enable && bank[IDX_GENERAL_THR][LP_DISABLES_BIT]
        |=> !monitor_active && !supply_ov_flag)
        else $error("monitor active in low power");

    AST_IRQ_QUIET: assert property (
        (irq_sources & ~irq_masks) == '0 |=> !interrupt_pin_oe)
        else $error("interrupt driven with all masked");

    AST_TRIGGER_MASKED: assert property (
        bank[IDX_TRIG_BASE][1:0] == 2'h1 |=> pin_trigger[0] == 1'b0)
        else $error("masked trigger not at level 0");

    AST_PIN_SYNC_ONLY: assert property (
        !bank[IDX_PIN_BASE + 4][PIN_FILT_BIT] && sync2[4] != filt[4]
        |=> filt[4] == $past(sync2[4]))
        else $error("unfiltered pin not passed in one cycle");

    AST_PIN_DRIVE: assert property (
        bank[IDX_PIN_BASE][PIN_SEL_LSB +: 3] != PIN_SEL_PLAIN
        |=> !pin_oe[0])
        else $error("alternate function pin driven");

    AST_GROUP_EXCLUSIVE: assert property (
        (safety_group_members & main_group_members) == '0)
        else $error("rail in both groups");

    AST_GROUP_DECODE: assert property (
        bank[IDX_GROUP_BASE + 2][3:2] == GROUP_SAFETY
        |=> safety_group_members[9])
        else $error("monitor rail not in safety group");

    AST_ACTION_DECODE: assert property (
        field2(bank[IDX_ACTION_TWO], 0) == 2'(PDCB_ORDERLY_OFF)
        |=> moderate_fault_action == PDCB_ORDERLY_OFF)
        else $error("moderate fault action not decoded");

    AST_READ_ANSWER: assert property (
        reg_read |=> reg_rvalid)
        else $error("read not answered");

    AST_FILTER_HOLDS: assert property (
        bank[IDX_PIN_BASE + 8][PIN_FILT_BIT] && sync2[8] != filt[8]
        && fcnt[8] == '0 |=> filt[8] == $past(filt[8]))
        else $error("filtered pin passed at once");

    AST_SLOW_OV_HOLDS: assert property (
        !bank[IDX_GENERAL_ONE][FAST_OVP_BIT] && sync2[CH_OV] != filt[CH_OV]
        && fcnt[CH_OV] == '0 |=> filt[CH_OV] == $past(filt[CH_OV]))
        else $error("slow overvoltage passed at once");

    AST_BUTTON_PRESS: assert property (
        field2(bank[IDX_STARTUP_PIN], START_SEL_LSB) == START_SEL_BUTTON
        && !filt[CH_STRT] |=> startup_request)
        else $error("button press not requested");

    COV_HOST_WRITE:  cover property (reg_write ##2 reg_read);
    COV_IRQ:         cover property (interrupt_pin_oe);
    COV_START:       cover property ($rose(startup_request));
    COV_SUPPLY_OV:   cover property (supply_ov_flag);
    COV_SELF_TEST:   cover property (boot_self_test_done);

endmodule : pdcb_config_bank

`default_nettype wire

// ==== sim/pdcb_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pdcb_host_model
    import pdcb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [7:0]       reg_rdata,
    input  wire logic             reg_rvalid,
    output var  logic             reg_write,
    output var  logic             reg_read,
    output var  logic [IDX_W-1:0] reg_index,
    output var  logic [7:0]       reg_wdata
);
    initial begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_index = '0;
        reg_wdata = '0;
    end

    // ------------------------------------------------------------
    // register accesses
    // ------------------------------------------------------------
    // idle bus shows the inverse, so a stale value never passes
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_write = 1'b1;
        reg_index = idx;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_write = 1'b0;
        reg_index = ~idx;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [IDX_W-1:0] idx, output logic [7:0] d,
                      output logic v);
        @(posedge clk);
        #1;
        reg_read  = 1'b1;
        reg_index = idx;
        @(posedge clk);
        #1;
        reg_read  = 1'b0;
        reg_index = ~idx;
        d         = reg_rdata;
        v         = reg_rvalid;
    endtask : rd
endmodule : pdcb_host_model

`default_nettype wire

// ==== sim/pmic_default_config_bank_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

module pmic_default_config_bank_bench
    import pdcb_pkg::*;
;
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wdata;
        logic [7:0] exp;
    } pdcb_row_t;

    logic           clk = 1'b0;
    logic           srst = 1'b1;
    logic           nvm_load = 1'b0;
    logic           bist_done = 1'b0;
    logic           lpm = 1'b0;
    logic [10:0]    pin_input = 11'h010;
    logic           button = 1'b0;
    logic           ov_raw = 1'b0;
    logic           uv_raw = 1'b0;
    logic [127:0]   irq_sources = '0;
    logic           wr_en, rd_en, rvalid, mon, ov_f, uv_f, req, irq_oe;
    logic [5:0]     idx;
    logic [7:0]     wdata, rdata, d;
    logic           v;
    logic [10:0]    pin_out, pin_oe, pin_trig;
    logic [9:0]     safe_m, main_m;
    pdcb_action_t   a_safe, a_main, a_other, a_severe, a_mod;
    int             n_fail = 0;
    int             checks_done = 0;
    logic [7:0]     defaults [42] = '{
        8'h03, 8'h3F, 8'h02, 8'h01, 8'h04, 8'h08, 8'h02, 8'h02, 8'h02,
        8'h02, 8'hC4, 8'hCC, 8'hC0, 8'h40, 8'h0B, 8'h58, 8'h00, 8'h00,
        8'h6A, 8'hA5, 8'h06, 8'h1E, 8'h01, 8'h55, 8'h55, 8'h15, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hFF, 8'hFF, 8'h3C, 8'h05,
        8'h04, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00};
    pdcb_row_t      rows [7] = '{'{6'h00, 8'hA5, 8'hA5},
        '{6'h0F, 8'hFF, 8'hFF}, '{6'h15, 8'h3C, 8'h3C},
        '{6'h1F, 8'h00, 8'h00}, '{6'h29, 8'h81, 8'h81},
        '{6'h2A, 8'h5A, 8'h00}, '{6'h3F, 8'hFF, 8'h00}};

    always #2 clk = ~clk;

    pdcb_config_bank #(.SUPPLY_CYCLES(8), .BUTTON_CYCLES(16)) dut (
        .clk(clk), .srst(srst), .nvm_load(nvm_load),
        .boot_self_test_done(bist_done), .low_power_mode_enable(lpm),
        .reg_write(wr_en), .reg_read(rd_en), .reg_index(idx),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .pin_input(pin_input), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_trigger(pin_trig), .power_button_input(button),
        .startup_request(req), .supply_ov_raw(ov_raw),
        .supply_uv_raw(uv_raw), .monitor_active(mon),
        .supply_ov_flag(ov_f), .supply_uv_flag(uv_f),
        .irq_sources(irq_sources), .interrupt_pin_oe(irq_oe),
        .safety_group_members(safe_m), .main_group_members(main_m),
        .safety_group_action(a_safe), .main_group_action(a_main),
        .other_group_action(a_other), .severe_fault_action(a_severe),
        .moderate_fault_action(a_mod));

    pdcb_host_model host (
        .clk(clk), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .reg_write(wr_en), .reg_read(rd_en), .reg_index(idx),
        .reg_wdata(wdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic rchk(input logic [5:0] i, input logic [7:0] e);
        host.rd(i, d, v);
        `CHK(d, e)
    endtask : rchk

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // run is about 5.4k cycles; the limit of 25k cycles leaves ample slack
    initial begin
        #100000;
        n_fail++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(3);
        srst = 1'b0;
        cyc(1);
        `CHK(mon, 1'b1)
        `CHK(pin_oe, 11'h03C)
        `CHK(pin_trig, 11'h000)
        `CHK(safe_m, 10'h238)
        `CHK(main_m, 10'h1C7)
        `CHK({a_safe, a_main, a_other, a_severe, a_mod}, 10'h2D1)
        for (int i = 0; i < 42; i++) begin
            host.rd(6'(i), d, v);
            `CHK({v, d}, {1'b1, defaults[i]})
        end
        foreach (rows[i]) begin
            host.wr(rows[i].idx, rows[i].wdata);
            rchk(rows[i].idx, rows[i].exp);
        end
        nvm_load = 1'b1;
        cyc(1);
        nvm_load = 1'b0;
        rchk(6'h00, 8'h03);
        rchk(6'h1F, 8'h03);
        for (int c = 0; c < 4; c++) begin
            host.wr(6'h15, {4{2'(c)}});
            cyc(2);
            `CHK({a_safe, a_severe}, {2'(c), 2'(c)})
        end
        // pin output levels follow the function select
        host.wr(6'h10, 8'h08);
        cyc(2);
        `CHK(pin_out, 11'h008)
        host.wr(6'h07, 8'h06);
        cyc(2);
        `CHK({pin_out, pin_oe}, {11'h000, 11'h034})
        host.wr(6'h0C, 8'h02);
        host.wr(6'h11, 8'h01);
        cyc(2);
        `CHK({pin_out, pin_oe}, {11'h100, 11'h134})
        // filtered and unfiltered pin triggers
        host.wr(6'h0C, 8'h80);
        host.wr(6'h19, 8'h14);
        pin_input[8] = 1'b1;
        cyc(1000);
        `CHK(pin_trig[8], 1'b0)
        cyc(1010);
        `CHK(pin_trig[8], 1'b1)
        host.wr(6'h19, 8'h10);
        pin_input[9] = 1'b1;
        cyc(2);
        `CHK(pin_trig[9], 1'b0)
        cyc(3);
        `CHK(pin_trig[9], 1'b1)
        host.wr(6'h18, 8'h57);
        cyc(2);
        `CHK(pin_trig[4], 1'b1)
        // startup pin in enable-level then button mode
        button = 1'b1;
        cyc(1000);
        `CHK(req, 1'b0)
        cyc(1010);
        `CHK(req, 1'b1)
        host.wr(6'h0F, 8'h59);
        cyc(2);
        `CHK(req, 1'b0)
        button = 1'b0;
        cyc(8);
        `CHK(req, 1'b0)
        cyc(16);
        `CHK(req, 1'b1)
        // supply monitor filters
        uv_raw = 1'b1;
        cyc(6);
        `CHK(uv_f, 1'b0)
        cyc(10);
        `CHK(uv_f, 1'b1)
        ov_raw = 1'b1;
        cyc(500);
        `CHK(ov_f, 1'b0)
        cyc(600);
        `CHK(ov_f, 1'b1)
        host.wr(6'h02, 8'h03);
        ov_raw = 1'b0;
        cyc(16);
        `CHK(ov_f, 1'b0)
        lpm = 1'b1;
        cyc(3);
        `CHK({mon, uv_f}, 2'b00)
        host.wr(6'h03, 8'h00);
        cyc(2);
        `CHK(mon, 1'b1)
        lpm = 1'b0;
        // interrupt gating and self-test mask clear
        irq_sources[0] = 1'b1;
        cyc(2);
        `CHK(irq_oe, 1'b1)
        host.wr(6'h1A, 8'h01);
        cyc(2);
        `CHK(irq_oe, 1'b0)
        irq_sources[40] = 1'b1;
        cyc(2);
        `CHK(irq_oe, 1'b0)
        bist_done = 1'b1;
        cyc(1);
        bist_done = 1'b0;
        cyc(2);
        `CHK(irq_oe, 1'b1)
        rchk(6'h1F, 8'h00);
        // second reset in mid-run
        srst = 1'b1;
        cyc(3);
        srst = 1'b0;
        cyc(1);
        `CHK({irq_oe, pin_trig[4]}, 2'b10)
        rchk(6'h1F, 8'h03);
        rchk(6'h0F, 8'h58);
        conclude();
    end
endmodule : pmic_default_config_bank_bench

`default_nettype wire
